// ===== pkg/bcr_pkg.sv
package bcr_pkg;
	localparam int AXI_AW = 8;
	localparam int AXI_DW = 32;
	localparam int AXI_SW = 4;

	// Byte addresses of the mapped words
	localparam logic [AXI_AW-1:0] ADDR_STATUS = 8'h04;
	localparam logic [AXI_AW-1:0] ADDR_REVCLASS = 8'h08;
	localparam logic [AXI_AW-1:0] ADDR_CACHE = 8'h0C;
	localparam logic [AXI_AW-1:0] ADDR_BUSNUM = 8'h18;

	// Status word field positions
	localparam int ST_INT_PEND = 19;
	localparam int ST_CAP_LIST = 20;
	localparam int ST_66MHZ = 21;
	localparam int ST_RSVD22 = 22;
	localparam int ST_FB2B = 23;
	localparam int ST_MDPE = 24;
	localparam int ST_SEL_LO = 25;
	localparam int ST_SEL_HI = 26;
	localparam int ST_STA = 27;
	localparam int ST_RTA = 28;
	localparam int ST_RMA = 29;
	localparam int ST_SSE = 30;
	localparam int ST_DPE = 31;
	localparam int ST_RSVD_LO = 16;
	localparam int ST_RSVD_HI = 18;

	// Byte lanes
	localparam int LANE_B0 = 0;
	localparam int LANE_B1 = 1;
	localparam int LANE_B2 = 2;
	localparam int LANE_B3 = 3;

	// Fixed identification and layout values
	localparam logic [7:0] CLASS_PROG_IF = 8'h00;
	localparam logic [7:0] CLASS_SUB = 8'h04;
	localparam logic [7:0] CLASS_BASE = 8'h06;
	localparam logic [7:0] LAYOUT_TYPE_VAL = 8'h01;
	localparam logic [7:0] LAT_TIMER_VAL = 8'h00;
	localparam logic [7:0] UNUSED_BYTE = 8'h00;
	localparam logic [15:0] STATUS_LOW_HALF = 16'h0000;

	// Reset values
	localparam logic [7:0] CACHE_RST = 8'h00;
	localparam logic [7:0] BUSNUM_RST = 8'h00;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [AXI_DW-1:0] DATA_ZERO = 32'h0000_0000;
endpackage

// ===== logic/bcr_evt_flag.sv
`timescale 1ns/100ps
module bcr_evt_flag (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Event and clear
	input wire logic set,
	input wire logic clr,
	// Flag
	output logic flag_q
);
	// Set wins over a same-cycle clear so no event is lost
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_q <= 1'b0;
		end else if (set) begin
			flag_q <= 1'b1;
		end else if (clr) begin
			flag_q <= 1'b0;
		end
	end
endmodule

// ===== logic/bcr_regs.sv
// Contract
// - Interrupt-pending status bit always reads zero; forwarded interrupts never touch it.
// - Capability-list bit reads one from reset onward.
// - 66 MHz, fast back-to-back and select timing bits read zero, ignore writes.
// - Master data parity flag sets on parity error when enabled; write-one clears.
// - Signaled target abort sets on completer-abort completion sent; read-only.
// - Received target abort sets on completer-abort completion received; resets zero.
// - Received master abort sets on unsupported-request completion received; resets zero.
// - Signaled system error sets on error message when reporting enabled; write-one clears.
// - Detected parity error sets on poisoned packet, unconditionally; write-one clears.
// - Revision byte is fixed in hardware and ignores writes.
// - Class code reads interface 00h, sub-class 04h, base class 06h.
// - Cache line size is read/write, resets 00h, affects nothing.
// - Both latency timer bytes read 00h and ignore writes.
// - Layout type byte reads 01h.
// - Upstream bus number is read/write, resets 00h.
// - Downstream bus number is read/write, resets 00h.
// - Highest downstream bus number is read/write, resets 00h.
// - Parity response enable gates parity flag setting.
// - System error enable gates error reporting flag.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
module bcr_regs #(
	// Arbitrary neutral value
	parameter logic [7:0] SILICON_REV = 8'h01
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [bcr_pkg::AXI_AW-1:0] awaddr,
	input wire logic [2:0] awprot,
	// AXI4-Lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [bcr_pkg::AXI_DW-1:0] wdata,
	input wire logic [bcr_pkg::AXI_SW-1:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [bcr_pkg::AXI_AW-1:0] araddr,
	input wire logic [2:0] arprot,
	// AXI4-Lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [bcr_pkg::AXI_DW-1:0] rdata,
	output logic [1:0] rresp,
	// Command enables
	input wire logic cmd_parity_resp_en,
	input wire logic cmd_serr_en,
	// Port events, one-cycle pulses
	input wire logic evt_parity_err,
	input wire logic evt_poisoned_rx,
	input wire logic evt_ca_cpl_sent,
	input wire logic evt_ca_cpl_rcvd,
	input wire logic evt_ur_cpl_rcvd,
	input wire logic evt_err_msg_sent,
	// Bus numbers for routing
	output logic [7:0] upstream_bus_number,
	output logic [7:0] downstream_bus_number,
	output logic [7:0] highest_downstream_bus
);
	import bcr_pkg::*;

	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [AXI_DW-1:0] rdata_q;
	logic [1:0] rresp_q;
	logic aw_hold_q;
	logic aw_hold_d;
	logic [AXI_AW-1:0] aw_addr_q;
	logic w_hold_q;
	logic w_hold_d;
	logic [AXI_DW-1:0] w_data_q;
	logic [AXI_SW-1:0] w_strb_q;
	logic [AXI_AW-1:0] rd_addr_q;
	logic [7:0] cache_line_size_q;
	logic [7:0] up_bus_q;
	logic [7:0] down_bus_q;
	logic [7:0] high_bus_q;
	logic wr_fire;
	logic ar_fire;
	logic [AXI_AW-1:0] wr_word;
	logic [AXI_AW-1:0] rd_word;
	logic wr_mapped;
	logic st_clr_en;
	logic mdpe_q;
	logic sta_q;
	logic rta_q;
	logic rma_q;
	logic sse_q;
	logic dpe_q;
	logic [AXI_DW-1:0] rd_mux;
	logic rd_mapped;

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign upstream_bus_number = up_bus_q;
	assign downstream_bus_number = down_bus_q;
	assign highest_downstream_bus = high_bus_q;

	// Write path: address and data are caught in either order
	assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
	assign aw_hold_d = (aw_hold_q && !wr_fire) || (awvalid && awready_q);
	assign w_hold_d = (w_hold_q && !wr_fire) || (wvalid && wready_q);
	assign wr_word = {aw_addr_q[AXI_AW-1:2], 2'b00};
	assign wr_mapped = (wr_word == ADDR_STATUS) || (wr_word == ADDR_REVCLASS) ||
		(wr_word == ADDR_CACHE) || (wr_word == ADDR_BUSNUM);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else begin
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			awready_q <= !aw_hold_d;
			wready_q <= !w_hold_d;
			if (awvalid && awready_q) begin
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready_q) begin
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_q && bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Writable fields; read-only bytes of the same words simply drop the write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cache_line_size_q <= CACHE_RST;
		end else if (wr_fire && wr_word == ADDR_CACHE && w_strb_q[LANE_B0]) begin
			// Stored for software only, nothing else reads it
			cache_line_size_q <= w_data_q[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			up_bus_q <= BUSNUM_RST;
			down_bus_q <= BUSNUM_RST;
			high_bus_q <= BUSNUM_RST;
		end else if (wr_fire && wr_word == ADDR_BUSNUM) begin
			if (w_strb_q[LANE_B0]) begin
				up_bus_q <= w_data_q[7:0];
			end
			if (w_strb_q[LANE_B1]) begin
				down_bus_q <= w_data_q[15:8];
			end
			if (w_strb_q[LANE_B2]) begin
				high_bus_q <= w_data_q[23:16];
			end
		end
	end

	// Status flags; clearable ones only through byte lane 3
	assign st_clr_en = wr_fire && wr_word == ADDR_STATUS && w_strb_q[LANE_B3];

	bcr_evt_flag u_mdpe (
		.aclk(aclk),
		.aresetn(aresetn),
		.set(evt_parity_err && cmd_parity_resp_en),
		.clr(st_clr_en && w_data_q[ST_MDPE]),
		.flag_q(mdpe_q)
	);

	bcr_evt_flag u_sse (
		.aclk(aclk),
		.aresetn(aresetn),
		.set(evt_err_msg_sent && cmd_serr_en),
		.clr(st_clr_en && w_data_q[ST_SSE]),
		.flag_q(sse_q)
	);

	bcr_evt_flag u_dpe (
		.aclk(aclk),
		.aresetn(aresetn),
		.set(evt_poisoned_rx),
		.clr(st_clr_en && w_data_q[ST_DPE]),
		.flag_q(dpe_q)
	);

	// Read-only abort flags: only reset clears them
	bcr_evt_flag u_sta (
		.aclk(aclk),
		.aresetn(aresetn),
		.set(evt_ca_cpl_sent),
		.clr(1'b0),
		.flag_q(sta_q)
	);

	bcr_evt_flag u_rta (
		.aclk(aclk),
		.aresetn(aresetn),
		.set(evt_ca_cpl_rcvd),
		.clr(1'b0),
		.flag_q(rta_q)
	);

	bcr_evt_flag u_rma (
		.aclk(aclk),
		.aresetn(aresetn),
		.set(evt_ur_cpl_rcvd),
		.clr(1'b0),
		.flag_q(rma_q)
	);

	// Read path
	assign rd_word = {araddr[AXI_AW-1:2], 2'b00};
	assign ar_fire = arvalid && arready_q;

	always_comb begin
		rd_mux = DATA_ZERO;
		rd_mapped = 1'b1;
		case (rd_word)
			ADDR_STATUS: begin
				rd_mux[15:0] = STATUS_LOW_HALF;
				rd_mux[ST_CAP_LIST] = 1'b1;
				rd_mux[ST_INT_PEND] = 1'b0;
				rd_mux[ST_66MHZ] = 1'b0;
				rd_mux[ST_FB2B] = 1'b0;
				rd_mux[ST_SEL_HI:ST_SEL_LO] = 2'b00;
				rd_mux[ST_RSVD_HI:ST_RSVD_LO] = 3'b000;
				rd_mux[ST_RSVD22] = 1'b0;
				rd_mux[ST_MDPE] = mdpe_q;
				rd_mux[ST_STA] = sta_q;
				rd_mux[ST_RTA] = rta_q;
				rd_mux[ST_RMA] = rma_q;
				rd_mux[ST_SSE] = sse_q;
				rd_mux[ST_DPE] = dpe_q;
			end
			ADDR_REVCLASS: begin
				rd_mux = {CLASS_BASE, CLASS_SUB, CLASS_PROG_IF, SILICON_REV};
			end
			ADDR_CACHE: begin
				rd_mux = {UNUSED_BYTE, LAYOUT_TYPE_VAL, LAT_TIMER_VAL, cache_line_size_q};
			end
			ADDR_BUSNUM: begin
				rd_mux = {LAT_TIMER_VAL, high_bus_q, down_bus_q, up_bus_q};
			end
			default: begin
				rd_mapped = 1'b0;
			end
		endcase
	end

	// One read in flight; arready drops while the answer waits for rready
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= DATA_ZERO;
			rresp_q <= RESP_OKAY;
			rd_addr_q <= '0;
		end else if (ar_fire) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
			rd_addr_q <= rd_word;
		end else if (rvalid_q && rready) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_INT_PEND_ZERO: assert property (
		rvalid_q && rd_addr_q == ADDR_STATUS |-> !rdata_q[ST_INT_PEND])
		else $error("interrupt pending bit read as one");
	AST_CAP_LIST_ONE: assert property (
		rvalid_q && rd_addr_q == ADDR_STATUS |-> rdata_q[ST_CAP_LIST])
		else $error("capability list bit read as zero");
	AST_LEGACY_ZERO: assert property (
		rvalid_q && rd_addr_q == ADDR_STATUS |->
		rdata_q[ST_SEL_HI:ST_SEL_LO] == 2'b00 && !rdata_q[ST_66MHZ] && !rdata_q[ST_FB2B])
		else $error("legacy status field read nonzero");
	AST_MDPE_SET: assert property (
		evt_parity_err && cmd_parity_resp_en |=> mdpe_q [*2] or (mdpe_q ##1 1'b1))
		else $error("parity flag missed an enabled error");
	AST_MDPE_GATED: assert property (
		!mdpe_q && !cmd_parity_resp_en |=> !mdpe_q)
		else $error("parity flag set while response disabled");
	AST_STA_STICKY: assert property (
		evt_ca_cpl_sent |=> sta_q ##1 sta_q)
		else $error("signaled target abort not set or not held");
	AST_RTA_SET: assert property (
		evt_ca_cpl_rcvd |=> rta_q)
		else $error("received target abort not set");
	AST_RMA_SET: assert property (
		$rose(rma_q) |-> $past(evt_ur_cpl_rcvd))
		else $error("received master abort set without cause");
	AST_SSE_SET: assert property (
		$rose(sse_q) |-> $past(evt_err_msg_sent) && $past(cmd_serr_en))
		else $error("system error flag set without enabled message");
	AST_DPE_W1C: assert property (
		dpe_q && st_clr_en && w_data_q[ST_DPE] && !evt_poisoned_rx |=> !dpe_q)
		else $error("detected parity flag not cleared by write of one");
	AST_DPE_SET_WINS: assert property (
		evt_poisoned_rx |=> dpe_q)
		else $error("detected parity flag missed a poisoned packet");
	AST_CLASS_FIXED: assert property (
		rvalid_q && rd_addr_q == ADDR_REVCLASS |->
		rdata_q == {CLASS_BASE, CLASS_SUB, CLASS_PROG_IF, SILICON_REV})
		else $error("class or revision word wrong");
	AST_LAYOUT_WORD: assert property (
		rvalid_q && rd_addr_q == ADDR_CACHE |->
		rdata_q[23:8] == {LAYOUT_TYPE_VAL, LAT_TIMER_VAL})
		else $error("layout type or latency byte wrong");
	AST_BUS_WRITE: assert property (
		wr_fire && wr_word == ADDR_BUSNUM && w_strb_q[LANE_B0] |=>
		upstream_bus_number == $past(w_data_q[7:0]) && bvalid)
		else $error("upstream bus number not written");
	AST_RSVD_ZERO: assert property (
		rvalid_q && rd_addr_q == ADDR_STATUS |->
		rdata_q[ST_RSVD_HI:ST_RSVD_LO] == 3'b000 && !rdata_q[ST_RSVD22])
		else $error("reserved status bits read nonzero");
endmodule

// ===== testbench/bcr_host.sv
`timescale 1ns/100ps
module bcr_host (
	// Clock
	input wire logic aclk,
	// Write channels
	output logic awvalid,
	input wire logic awready,
	output logic [bcr_pkg::AXI_AW-1:0] awaddr,
	output logic wvalid,
	input wire logic wready,
	output logic [bcr_pkg::AXI_DW-1:0] wdata,
	output logic [bcr_pkg::AXI_SW-1:0] wstrb,
	input wire logic bvalid,
	output logic bready,
	input wire logic [1:0] bresp,
	// Read channels
	output logic arvalid,
	input wire logic arready,
	output logic [bcr_pkg::AXI_AW-1:0] araddr,
	input wire logic rvalid,
	output logic rready,
	input wire logic [bcr_pkg::AXI_DW-1:0] rdata,
	input wire logic [1:0] rresp,
	// Stall report
	output logic hung
);
	import bcr_pkg::*;
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, hung} = 6'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
	end
	// Released address and data lines toggle so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] resp);
		int n;
		resp = 2'h3;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~d;
			end
			if (bvalid && bready) begin
				resp = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (n == 64)
			hung <= 1'b1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		resp = 2'h3;
		d = 32'hDEAD_BEEF;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
			if (rvalid && rready) begin
				d = rdata;
				resp = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (n == 64)
			hung <= 1'b1;
	endtask
endmodule

// ===== testbench/bcr_regs_tb.sv
`timescale 1ns/100ps
module bcr_regs_tb;
	import bcr_pkg::*;
	logic aclk = 1'b0;
	logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
	logic rvalid, rready, hung, cmd_pe, cmd_se;
	logic [7:0] awaddr, araddr, up, down, high;
	logic [31:0] wdata, rdata, exp;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [5:0] evt;
	int err_count, comparisons;
	int pos[6] = '{24, 31, 27, 28, 29, 30};
	always #2.5 aclk = ~aclk;
	bcr_regs dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .cmd_parity_resp_en(cmd_pe), .cmd_serr_en(cmd_se),
		.evt_parity_err(evt[0]), .evt_poisoned_rx(evt[1]), .evt_ca_cpl_sent(evt[2]),
		.evt_ca_cpl_rcvd(evt[3]), .evt_ur_cpl_rcvd(evt[4]), .evt_err_msg_sent(evt[5]),
		.upstream_bus_number(up), .downstream_bus_number(down), .highest_downstream_bus(high));
	bcr_host u_host (.aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .hung(hung));
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		comparisons++;
		if (got !== want) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] want, input logic [1:0] wr_);
		logic [31:0] d;
		logic [1:0] r;
		u_host.rd(a, d, r);
		chk(d, want);
		chk({30'h0, r}, {30'h0, wr_});
	endtask
	task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] wr_);
		logic [1:0] r;
		u_host.wr(a, d, s, r);
		chk({30'h0, r}, {30'h0, wr_});
	endtask
	// Events are one-cycle pulses on the core clock
	task automatic pulse(input int i);
		@(posedge aclk);
		evt <= 6'h01 << i;
		@(posedge aclk);
		evt <= 6'h00;
	endtask
	task automatic do_reset();
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge hung) begin
		err_count++;
		$display("unexpected at %0t: bus handshake timed out", $time);
		results();
	end
	initial begin
		aresetn = 1'b0;
		cmd_pe = 1'b0;
		cmd_se = 1'b0;
		evt = 6'h00;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(ADDR_STATUS, 32'h0010_0000, RESP_OKAY);
		rdc(ADDR_REVCLASS, 32'h0604_0001, RESP_OKAY);
		rdc(ADDR_CACHE, 32'h0001_0000, RESP_OKAY);
		rdc(ADDR_BUSNUM, 32'h0000_0000, RESP_OKAY);
		wrc(ADDR_STATUS, 32'h00FF_FFFF, 4'hF, RESP_OKAY);
		rdc(ADDR_STATUS, 32'h0010_0000, RESP_OKAY);
		wrc(ADDR_REVCLASS, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
		rdc(ADDR_REVCLASS, 32'h0604_0001, RESP_OKAY);
		wrc(ADDR_CACHE, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
		rdc(ADDR_CACHE, 32'h0001_00FF, RESP_OKAY);
		wrc(ADDR_BUSNUM, 32'hFFC3_B2A1, 4'hF, RESP_OKAY);
		rdc(ADDR_BUSNUM, 32'h00C3_B2A1, RESP_OKAY);
		wrc(ADDR_BUSNUM, 32'h0000_5500, 4'h2, RESP_OKAY);
		rdc(ADDR_BUSNUM, 32'h00C3_55A1, RESP_OKAY);
		chk({8'h00, high, down, up}, 32'h00C3_55A1);
		wrc(8'h00, 32'h0000_0001, 4'hF, RESP_SLVERR);
		rdc(8'h10, 32'h0000_0000, RESP_SLVERR);
		// With both enables off only the ungated flags may appear
		exp = 32'h0010_0000;
		for (int i = 0; i < 6; i++) begin
			pulse(i);
			if (i != 0 && i != 5)
				exp[pos[i]] = 1'b1;
			rdc(ADDR_STATUS, exp, RESP_OKAY);
		end
		cmd_pe <= 1'b1;
		cmd_se <= 1'b1;
		pulse(0);
		pulse(5);
		rdc(ADDR_STATUS, 32'hF910_0000, RESP_OKAY);
		wrc(ADDR_STATUS, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
		rdc(ADDR_STATUS, 32'h3810_0000, RESP_OKAY);
		do_reset();
		rdc(ADDR_STATUS, 32'h0010_0000, RESP_OKAY);
		rdc(ADDR_CACHE, 32'h0001_0000, RESP_OKAY);
		rdc(ADDR_BUSNUM, 32'h0000_0000, RESP_OKAY);
		chk({8'h00, high, down, up}, 32'h0000_0000);
		results();
	end
endmodule
